/* File: src/lsm_pkg.sv */
package lsm_pkg;

  // architectural register numbers, reset values, step, mask and field widths for the sequencer
  localparam logic [3:0]  SP_REG        = 4'hD;
  localparam logic [3:0]  PC_REG        = 4'hF;
  localparam logic [3:0]  REG_RESET     = 4'h0;
  localparam logic [31:0] WORD_STEP     = 32'h4;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFFFFFE;
  localparam logic [31:0] WORD_RESET    = 32'h0;
  localparam logic [15:0] LIST_RESET    = 16'h0;
  localparam int          OFFSET_W      = 13;
  localparam int          UNPRIV_OFF_W  = 8;

  // operations as presented by the instruction front end
  typedef enum logic [3:0] {
    OP_LOAD_UNPRIV,
    OP_STORE_UNPRIV,
    OP_LOAD_PCREL,
    OP_MULTI_WORD_LOAD,
    OP_MULTI_WORD_LOAD_ASCENDING,
    OP_FULL_DESCENDING_STACK_LOAD,
    OP_MULTI_WORD_LOAD_DESCENDING,
    OP_EMPTY_ASCENDING_STACK_LOAD,
    OP_MULTI_WORD_STORE,
    OP_MULTI_WORD_STORE_ASCENDING,
    OP_EMPTY_ASCENDING_STACK_STORE,
    OP_MULTI_WORD_STORE_DESCENDING,
    OP_FULL_DESCENDING_STACK_STORE,
    OP_STACK_PUSH,
    OP_STACK_POP
  } lsm_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_HALF,
    SZ_WORD,
    SZ_DUAL
  } lsm_size_e;

  typedef struct packed {
    logic load;
    logic desc;
    logic multi;
    logic pcrel;
    logic unpriv;
    logic stack;
  } lsm_dec_s;

  // aliases fold onto four multi-word forms; plain forms default to increment_after
  function automatic lsm_dec_s lsm_decode(input lsm_op_e op);
    lsm_dec_s d;
    d = '0;
    unique case (op)
      OP_LOAD_UNPRIV:                 begin d.load = 1'h1; d.unpriv = 1'h1; end
      OP_STORE_UNPRIV:                d.unpriv = 1'h1;
      OP_LOAD_PCREL:                  begin d.load = 1'h1; d.pcrel = 1'h1; end
      OP_MULTI_WORD_LOAD,
      OP_MULTI_WORD_LOAD_ASCENDING,
      OP_FULL_DESCENDING_STACK_LOAD:  begin d.load = 1'h1; d.multi = 1'h1; end
      OP_MULTI_WORD_LOAD_DESCENDING,
      OP_EMPTY_ASCENDING_STACK_LOAD:  begin d.load = 1'h1; d.multi = 1'h1; d.desc = 1'h1; end
      OP_MULTI_WORD_STORE,
      OP_MULTI_WORD_STORE_ASCENDING,
      OP_EMPTY_ASCENDING_STACK_STORE: d.multi = 1'h1;
      OP_MULTI_WORD_STORE_DESCENDING,
      OP_FULL_DESCENDING_STACK_STORE: begin d.multi = 1'h1; d.desc = 1'h1; end
      OP_STACK_PUSH:                  begin d.multi = 1'h1; d.desc = 1'h1; d.stack = 1'h1; end
      OP_STACK_POP:
      begin
        d.load  = 1'h1;
        d.multi = 1'h1;
        d.stack = 1'h1;
      end
      default:                        d = '0;
    endcase
    return d;
  endfunction

endpackage

/* File: src/lsm_extend.sv */
`timescale 1ns/100ps
// picks the addressed lane out of a read word and widens it
module lsm_extend (
  // read data and access shape
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  lane,
  input  wire logic [1:0]  size,
  input  wire logic        sign,
  // widened result
  output logic      [31:0] word
);

  logic [31:0] shifted;

  always_comb
  begin
    shifted = rdata >> {lane, 3'h0};
    unique case (lsm_pkg::lsm_size_e'(size))
      lsm_pkg::SZ_BYTE: word = {{24{sign & shifted[7]}}, shifted[7:0]};
      lsm_pkg::SZ_HALF: word = {{16{sign & shifted[15]}}, shifted[15:0]};
      default:          word = rdata;
    endcase
  end

endmodule

/* File: src/lsm_unit.sv */
`timescale 1ns/100ps
module lsm_unit (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // decoded instruction
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire lsm_pkg::lsm_op_e        cmd_op,
  input  wire logic [1:0]              cmd_size,
  input  wire logic                    cmd_signed,
  input  wire logic                    cmd_priv,
  input  wire logic [3:0]              cmd_rt,
  input  wire logic [3:0]              cmd_rt2,
  input  wire logic [3:0]              cmd_base,
  input  wire logic [12:0]             cmd_offset,
  input  wire logic [15:0]             cmd_list,
  input  wire logic                    cmd_writeback,
  input  wire logic [31:0]             cmd_pc,
  // register file
  output logic      [3:0]              reg_rd_addr,
  input  wire logic [31:0]             reg_rd_data,
  output logic                         reg_wr_en,
  output logic      [3:0]              reg_wr_addr,
  output logic      [31:0]             reg_wr_data,
  output logic                         branch_en,
  output logic      [31:0]             branch_target,
  output logic                         flags_we,
  // memory bus
  output logic                         mem_req,
  output logic                         mem_write,
  output logic      [1:0]              mem_size,
  output logic                         mem_unpriv,
  output logic      [31:0]             mem_addr,
  output logic      [31:0]             mem_wdata,
  input  wire logic                    mem_done,
  input  wire logic [31:0]             mem_rdata
);

  typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_FINISH} lsm_state_e;

  function automatic logic [3:0] lowest_reg(input logic [15:0] m);
    logic [3:0] r;
    r = lsm_pkg::REG_RESET;
    for (int i = 15; i >= 0; i--)
      if (m[i])
        r = 4'(i);
    return r;
  endfunction

  function automatic logic [3:0] highest_reg(input logic [15:0] m);
    logic [3:0] r;
    r = lsm_pkg::REG_RESET;
    for (int i = 0; i < 16; i++)
      if (m[i])
        r = 4'(i);
    return r;
  endfunction

  lsm_state_e         state, next_state;
  lsm_pkg::lsm_dec_s  dec, next_dec;
  logic [1:0]         size, next_size;
  logic               sign, next_sign, unpriv, next_unpriv, wb_en, next_wb_en;
  logic               beat, next_beat;
  logic [3:0]         base_reg, next_base_reg, rt2, next_rt2, cur_reg, next_cur_reg;
  logic [15:0]        remain, next_remain;
  logic [31:0]        addr, next_addr, wb_value, next_wb_value;
  logic               next_mem_req, next_mem_write, next_mem_unpriv;
  logic [1:0]         next_mem_size;
  logic [31:0]        next_mem_addr, next_mem_wdata;
  logic               next_reg_wr_en, next_branch_en;
  logic [3:0]         next_reg_wr_addr;
  logic [31:0]        next_reg_wr_data, next_branch_target;
  lsm_pkg::lsm_dec_s  cmd_dec;
  logic [4:0]         count;
  logic [31:0]        span, ld_word;
  logic [15:0]        left;
  logic               more;

  lsm_extend u_extend (
    .rdata (mem_rdata),
    .lane  (addr[1:0]),
    .size  (size),
    .sign  (sign),
    .word  (ld_word)
  );

  assign cmd_dec     = lsm_pkg::lsm_decode(cmd_op);
  assign cmd_ready   = (state == S_IDLE);
  assign flags_we    = 1'h0;
  assign reg_rd_addr = (state == S_IDLE) ? (cmd_dec.stack ? lsm_pkg::SP_REG : cmd_base) : cur_reg;
  assign left        = remain & ~(16'h1 << cur_reg);
  assign more        = dec.multi ? (left != lsm_pkg::LIST_RESET) :
                       (size == lsm_pkg::SZ_DUAL && !beat);

  always_comb
  begin
    count = '0;
    for (int i = 0; i < 16; i++)
      count = count + {4'h0, cmd_list[i]};
    span = {25'h0, count - 5'h1, 2'h0};
  end

  always_comb
  begin
    next_state = state;  next_dec = dec;  next_size = size;  next_sign = sign;
    next_unpriv = unpriv;  next_wb_en = wb_en;  next_beat = beat;  next_base_reg = base_reg;
    next_rt2 = rt2;  next_cur_reg = cur_reg;  next_remain = remain;  next_addr = addr;
    next_wb_value = wb_value;  next_mem_req = mem_req;  next_mem_write = mem_write;
    next_mem_unpriv = mem_unpriv;  next_mem_size = mem_size;  next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;  next_reg_wr_en = 1'h0;  next_reg_wr_addr = reg_wr_addr;
    next_reg_wr_data = reg_wr_data;  next_branch_en = 1'h0;  next_branch_target = branch_target;
    unique case (state)
      S_IDLE:
        if (cmd_valid)
        begin
          next_dec      = cmd_dec;
          next_size     = cmd_dec.multi ? lsm_pkg::SZ_WORD : cmd_size;
          next_sign     = cmd_signed & cmd_dec.load;
          next_unpriv   = cmd_dec.unpriv | ~cmd_priv;
          next_wb_en    = cmd_dec.multi & (cmd_writeback | cmd_dec.stack);
          next_base_reg = cmd_dec.stack ? lsm_pkg::SP_REG : cmd_base;
          next_rt2      = cmd_rt2;
          next_beat     = 1'h0;
          next_remain   = cmd_dec.multi ? cmd_list : lsm_pkg::LIST_RESET;
          next_cur_reg  = !cmd_dec.multi ? cmd_rt :
                          cmd_dec.desc ? highest_reg(cmd_list) : lowest_reg(cmd_list);
          next_wb_value = cmd_dec.desc ? reg_rd_data - span : reg_rd_data + span;
          if (cmd_dec.pcrel)
            next_addr = cmd_pc + {{19{cmd_offset[12]}}, cmd_offset};
          else if (cmd_dec.unpriv)
            next_addr = reg_rd_data + {24'h0, cmd_offset[7:0]};
          else
            next_addr = reg_rd_data;
          next_state = S_ISSUE;
        end
      S_ISSUE:
      begin
        next_mem_req    = 1'h1;
        next_mem_write  = ~dec.load;
        next_mem_unpriv = unpriv;
        next_mem_size   = (size == lsm_pkg::SZ_DUAL) ? lsm_pkg::SZ_WORD : size;
        next_mem_addr   = addr;
        unique case (lsm_pkg::lsm_size_e'(size))
          lsm_pkg::SZ_BYTE: next_mem_wdata = {4{reg_rd_data[7:0]}};
          lsm_pkg::SZ_HALF: next_mem_wdata = {2{reg_rd_data[15:0]}};
          default:          next_mem_wdata = reg_rd_data;
        endcase
        next_state = S_WAIT;
      end
      S_WAIT:
        if (mem_done)
        begin
          next_mem_req = 1'h0;
          if (dec.load && cur_reg == lsm_pkg::PC_REG)
          begin
            next_branch_en     = 1'h1;
            next_branch_target = ld_word & lsm_pkg::PC_ALIGN_MASK;
          end
          else if (dec.load)
          begin
            next_reg_wr_en   = 1'h1;
            next_reg_wr_addr = cur_reg;
            next_reg_wr_data = ld_word;
          end
          next_remain = left;
          if (more)
          begin
            next_addr    = dec.desc ? addr - lsm_pkg::WORD_STEP :
                           addr + lsm_pkg::WORD_STEP;
            next_cur_reg = !dec.multi ? rt2 : dec.desc ? highest_reg(left) : lowest_reg(left);
            next_beat    = 1'h1;
            next_state   = S_ISSUE;
          end
          else
            next_state = wb_en ? S_FINISH : S_IDLE;
        end
      S_FINISH:
      begin
        next_reg_wr_en   = 1'h1;
        next_reg_wr_addr = base_reg;
        next_reg_wr_data = wb_value;
        next_state       = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;  dec <= '0;  size <= lsm_pkg::SZ_WORD;  sign <= 1'h0;
      unpriv <= 1'h0;  wb_en <= 1'h0;  beat <= 1'h0;  base_reg <= lsm_pkg::REG_RESET;
      rt2 <= lsm_pkg::REG_RESET;  cur_reg <= lsm_pkg::REG_RESET;  remain <= lsm_pkg::LIST_RESET;
      addr <= lsm_pkg::WORD_RESET;  wb_value <= lsm_pkg::WORD_RESET;  mem_req <= 1'h0;
      mem_write <= 1'h0;  mem_unpriv <= 1'h0;  mem_size <= lsm_pkg::SZ_WORD;
      mem_addr <= lsm_pkg::WORD_RESET;  mem_wdata <= lsm_pkg::WORD_RESET;  reg_wr_en <= 1'h0;
      reg_wr_addr <= lsm_pkg::REG_RESET;  reg_wr_data <= lsm_pkg::WORD_RESET;
      branch_en <= 1'h0;  branch_target <= lsm_pkg::WORD_RESET;
    end
    else if (ce)
    begin
      state <= next_state;  dec <= next_dec;  size <= next_size;  sign <= next_sign;
      unpriv <= next_unpriv;  wb_en <= next_wb_en;  beat <= next_beat;  base_reg <= next_base_reg;
      rt2 <= next_rt2;  cur_reg <= next_cur_reg;  remain <= next_remain;  addr <= next_addr;
      wb_value <= next_wb_value;  mem_req <= next_mem_req;  mem_write <= next_mem_write;
      mem_unpriv <= next_mem_unpriv;  mem_size <= next_mem_size;  mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;  reg_wr_en <= next_reg_wr_en;  reg_wr_addr <= next_reg_wr_addr;
      reg_wr_data <= next_reg_wr_data;  branch_en <= next_branch_en;
      branch_target <= next_branch_target;
    end
  end

  // checks; take and done only count enabled cycles
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic take, done;
  assign take = ce && state == S_IDLE && cmd_valid;
  assign done = ce && state == S_WAIT && mem_done;

  property p_unpriv_flag;
    mem_req && dec.unpriv |-> mem_unpriv;
  endproperty
  a_unpriv_flag: assert property (p_unpriv_flag) else $error("form not unprivileged");
  // an enabled cycle after the take is the issue cycle, so the request follows it
  property p_user_plain;
    take && !cmd_priv ##1 ce |=> mem_req && mem_unpriv;
  endproperty
  a_user_plain: assert property (p_user_plain) else $error("user access privileged");
  property p_unpriv_addr;
    take && cmd_dec.unpriv |=> addr == $past(reg_rd_data) + {24'h0, $past(cmd_offset[7:0])};
  endproperty
  a_unpriv_addr: assert property (p_unpriv_addr) else $error("offset address wrong");
  property p_zero_byte;
    done && dec.load && size == lsm_pkg::SZ_BYTE && !sign && cur_reg != lsm_pkg::PC_REG
      |=> reg_wr_en && reg_wr_data[31:8] == 24'h0;
  endproperty
  a_zero_byte: assert property (p_zero_byte) else $error("byte not zero extended");
  property p_pcrel_addr;
    take && cmd_dec.pcrel
      |=> addr == $past(cmd_pc) + {{19{$past(cmd_offset[12])}}, $past(cmd_offset)};
  endproperty
  a_pcrel_addr: assert property (p_pcrel_addr) else $error("pc address wrong");
  property p_pc_branch;
    done && dec.load && cur_reg == lsm_pkg::PC_REG
      |=> branch_en && !reg_wr_en && branch_target == ($past(ld_word) & lsm_pkg::PC_ALIGN_MASK);
  endproperty
  a_pc_branch: assert property (p_pc_branch) else $error("pc load did not branch");
  property p_step_up;
    done && dec.multi && !dec.desc && more |=> addr == $past(addr) + lsm_pkg::WORD_STEP;
  endproperty
  a_step_up: assert property (p_step_up) else $error("ascending step wrong");
  property p_step_down;
    done && dec.multi && dec.desc && more |=> addr == $past(addr) - lsm_pkg::WORD_STEP;
  endproperty
  a_step_down: assert property (p_step_down) else $error("descending step wrong");
  property p_word_only;
    mem_req && dec.multi |-> mem_size == lsm_pkg::SZ_WORD;
  endproperty
  a_word_only: assert property (p_word_only) else $error("multi transfer not word");
  property p_stack_base;
    take && cmd_op == lsm_pkg::OP_STACK_PUSH |=> base_reg == lsm_pkg::SP_REG && wb_en && dec.desc;
  endproperty
  a_stack_base: assert property (p_stack_base) else $error("push base not sp");
  property p_no_flags;
    !flags_we;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("flags written");

  c_pop:   cover property (take && cmd_op == lsm_pkg::OP_STACK_POP);
  c_wb:    cover property (ce && state == S_FINISH);
  c_dual:  cover property (done && size == lsm_pkg::SZ_DUAL && beat);
  c_brnch: cover property (branch_en);

endmodule

/* File: sim/lsm_mem_model.sv */
`timescale 1ns/100ps
// far-side memory: answers each request after lat extra cycles
module lsm_mem_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // bus
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [1:0]  lat,
  output logic             mem_done,
  output logic      [31:0] mem_rdata
);
  logic [1:0]  cnt;
  logic [1:0]  next_cnt;
  logic        next_done;
  logic [31:0] next_rdata;

  always_comb
  begin
    next_done  = mem_req && !mem_done && cnt == lat;
    next_cnt   = (mem_req && !mem_done && !next_done) ? cnt + 2'h1 : 2'h0;
    // junk between answers: the word is inverted each cycle, so the cycle after an answer never shows the answered word
    next_rdata = next_done ? mem_addr ^ 32'hF0F08081 : ~mem_rdata;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt       <= 2'h0;
      mem_done  <= 1'h0;
      mem_rdata <= 32'h0;
    end
    else
    begin
      cnt       <= next_cnt;
      mem_done  <= next_done;
      mem_rdata <= next_rdata;
    end
  end
endmodule

/* File: sim/lsm_unit_tb.sv */
`timescale 1ns/100ps
module lsm_unit_tb;
  typedef struct packed {
    logic [3:0]  op;
    logic [1:0]  sz;
    logic        sg;
    logic        pv;
    logic [3:0]  rt;
    logic [3:0]  bs;
    logic [12:0] off;
    logic [15:0] lst;
    logic        wb;
    logic [31:0] ex;
  } lsm_row_s;

  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic        ce = 1'h1;
  logic        cmd_valid = 1'h0;
  lsm_row_s    cur = '0;
  logic [1:0]  lat = 2'h0;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic        cmd_ready, reg_wr_en, branch_en, flags_we;
  logic        mem_req, mem_write, mem_unpriv, mem_done;
  logic [1:0]  mem_size;
  logic [3:0]  reg_rd_addr, reg_wr_addr;
  logic [31:0] reg_wr_data, branch_target, mem_addr, mem_wdata, mem_rdata;

  // op codes in lsm_op_e order, size in lsm_size_e order; expectation is the first address
  // only legal registers, non-empty lists, no conditional pc loads
  lsm_row_s rows [19] = '{
    '{4'h0, 2'h0, 1'h0, 1'h1, 4'h1, 4'h2, 13'h00FF, 16'h0000, 1'h0, 32'h0010211F},
    '{4'h0, 2'h1, 1'h1, 1'h0, 4'h3, 4'h4, 13'h0002, 16'h0000, 1'h0, 32'h00104042},
    '{4'h1, 2'h0, 1'h0, 1'h1, 4'h6, 4'h5, 13'h0000, 16'h0000, 1'h0, 32'h00105050},
    '{4'h2, 2'h0, 1'h1, 1'h0, 4'h7, 4'h0, 13'h1001, 16'h0000, 1'h0, 32'h00001001},
    '{4'h2, 2'h1, 1'h0, 1'h1, 4'h7, 4'h0, 13'h0FFE, 16'h0000, 1'h0, 32'h00002FFE},
    '{4'h2, 2'h2, 1'h0, 1'h1, 4'hF, 4'h0, 13'h0004, 16'h0000, 1'h0, 32'h00002004},
    '{4'h2, 2'h3, 1'h0, 1'h1, 4'h8, 4'h0, 13'h1C04, 16'h0000, 1'h0, 32'h00001C04},
    '{4'h3, 2'h2, 1'h0, 1'h1, 4'h0, 4'h4, 13'h0000, 16'h0205, 1'h0, 32'h00104040},
    '{4'h4, 2'h2, 1'h0, 1'h1, 4'h0, 4'h4, 13'h0000, 16'h8003, 1'h1, 32'h00104040},
    '{4'h5, 2'h2, 1'h0, 1'h1, 4'h0, 4'h5, 13'h0000, 16'h0C00, 1'h1, 32'h00105050},
    '{4'h6, 2'h2, 1'h0, 1'h1, 4'h0, 4'h4, 13'h0000, 16'h00A1, 1'h1, 32'h00104040},
    '{4'h7, 2'h2, 1'h0, 1'h1, 4'h0, 4'h5, 13'h0000, 16'h0006, 1'h0, 32'h00105050},
    '{4'h8, 2'h2, 1'h0, 1'h1, 4'h0, 4'h4, 13'h0000, 16'h0003, 1'h1, 32'h00104040},
    '{4'h9, 2'h2, 1'h0, 1'h1, 4'h0, 4'h5, 13'h0000, 16'h4001, 1'h0, 32'h00105050},
    '{4'hA, 2'h2, 1'h0, 1'h1, 4'h0, 4'h2, 13'h0000, 16'h0018, 1'h1, 32'h00102020},
    '{4'hB, 2'h2, 1'h0, 1'h1, 4'h0, 4'h4, 13'h0000, 16'h1060, 1'h1, 32'h00104040},
    '{4'hC, 2'h2, 1'h0, 1'h1, 4'h0, 4'h5, 13'h0000, 16'h000F, 1'h0, 32'h00105050},
    '{4'hD, 2'h2, 1'h0, 1'h1, 4'h0, 4'h0, 13'h0000, 16'h4010, 1'h0, 32'h0010D0D0},
    '{4'hE, 2'h2, 1'h0, 1'h1, 4'h0, 4'h0, 13'h0000, 16'h8001, 1'h0, 32'h0010D0D0}
  };

  // register file contents are fixed so every expectation stays a pure function
  function automatic logic [31:0] rv(input logic [3:0] i);
    return 32'h00100000 | {16'h0, i, 4'h0, i, 4'h0};
  endfunction

  function automatic logic [31:0] xt(input logic [31:0] w, input logic [1:0] ln,
                                     input logic [1:0] sz, input logic s);
    logic [31:0] v;
    v = w >> {ln, 3'h0};
    if (sz == 2'h0)
      return s ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]};
    if (sz == 2'h1)
      return s ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
    return w;
  endfunction

  always #20 clock = ~clock;

  lsm_unit i_dut (
    .clock, .rst, .ce, .cmd_valid, .cmd_ready,
    .cmd_op(lsm_pkg::lsm_op_e'(cur.op)), .cmd_size(cur.sz), .cmd_signed(cur.sg),
    .cmd_priv(cur.pv), .cmd_rt(cur.rt), .cmd_rt2(cur.rt + 4'h1), .cmd_base(cur.bs),
    .cmd_offset(cur.off), .cmd_list(cur.lst), .cmd_writeback(cur.wb),
    .cmd_pc(32'h00002000), .reg_rd_addr, .reg_rd_data(rv(reg_rd_addr)), .reg_wr_en,
    .reg_wr_addr, .reg_wr_data, .branch_en, .branch_target, .flags_we, .mem_req,
    .mem_write, .mem_size, .mem_unpriv, .mem_addr, .mem_wdata, .mem_done, .mem_rdata
  );

  lsm_mem_model i_mem (.clock, .rst, .mem_req, .mem_addr, .lat, .mem_done, .mem_rdata);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic run(input lsm_row_s r);
    logic        ld, ds, mu, up;
    logic [3:0]  q[$];
    logic [31:0] a, ex, v;
    int          n;
    mu = r.op >= 4'h3;
    up = r.op <= 4'h1;
    ld = r.op inside {4'h0, 4'h2, [4'h3:4'h7], 4'hE};
    ds = r.op inside {4'h6, 4'h7, 4'hB, 4'hC, 4'hD};
    for (int i = 0; i < 16; i++)
      if (mu && r.lst[ds ? 15 - i : i])
        q.push_back(4'(ds ? 15 - i : i));
    if (!mu)
      q.push_back(r.rt);
    if (!mu && r.sz == 2'h3)
      q.push_back(r.rt + 4'h1);
    @(posedge clock);
    cur <= r;
    cmd_valid <= 1'h1;
    @(posedge clock);
    cmd_valid <= 1'h0;
    foreach (q[k])
    begin
      a = ds ? r.ex - 32'(4 * k) : r.ex + 32'(4 * k);
      v = rv(q[k]);
      for (n = 0; n < 50 && mem_req !== 1'h1; n++) @(posedge clock) #1;
      chk("addr", mem_addr, a);
      chk("write", mem_write, !ld);
      chk("unpriv", mem_unpriv, up | !r.pv);
      chk("size", mem_size, (mu || r.sz == 2'h3) ? 2'h2 : r.sz);
      chk("flags", flags_we, 1'h0);
      if (!ld)
        chk("wdata", mem_wdata, (!mu && r.sz == 2'h0) ? {4{v[7:0]}} : v);
      for (n = 0; n < 50 && mem_done !== 1'h1; n++) @(posedge clock) #1;
      @(posedge clock) #1;
      ex = xt(a ^ 32'hF0F08081, a[1:0], mu ? 2'h2 : r.sz, r.sg);
      if (ld && q[k] == 4'hF)
      begin
        chk("branch", branch_en, 1'h1);
        chk("target", branch_target, ex & ~32'h1);
      end
      else if (ld)
      begin
        chk("wr_en", reg_wr_en, 1'h1);
        chk("wr_addr", reg_wr_addr, q[k]);
        chk("wr_data", reg_wr_data, ex);
      end
    end
    if (r.wb || r.op >= 4'hD)
    begin
      v = mu && r.op >= 4'hD ? 32'hD : r.bs;
      for (n = 0; n < 20 && !(reg_wr_en === 1'h1 && reg_wr_addr === v[3:0]); n++)
        @(posedge clock) #1;
      chk("wb_en", reg_wr_en, 1'h1);
      chk("wb_data", reg_wr_data, a);
    end
    for (n = 0; n < 50 && cmd_ready !== 1'h1; n++) @(posedge clock) #1;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    #1;
    chk("rst_ready", cmd_ready, 1'h1);
    chk("rst_req", mem_req | reg_wr_en | branch_en | flags_we, 1'h0);
    chk("rst_size", mem_size, 2'h2);
    foreach (rows[i])
    begin
      lat <= 2'(i);
      run(rows[i]);
    end
    // ce low must freeze the unit: an offered command is not taken
    @(posedge clock);
    ce <= 1'h0;
    cur <= rows[2];
    cmd_valid <= 1'h1;
    repeat (3) @(posedge clock);
    cmd_valid <= 1'h0;
    ce <= 1'h1;
    repeat (2) @(posedge clock) #1;
    chk("ce_hold", mem_req, 1'h0);
    // reset in mid-transfer, then a command straight after release
    @(posedge clock);
    cur <= rows[17];
    cmd_valid <= 1'h1;
    @(posedge clock);
    cmd_valid <= 1'h0;
    repeat (3) @(posedge clock);
    rst <= 1'h1;
    #1;
    chk("mid_rst_req", mem_req, 1'h0);
    chk("mid_rst_ready", cmd_ready, 1'h1);
    @(posedge clock);
    rst <= 1'h0;
    run(rows[0]);
    report_and_stop();
  end
endmodule
